// ### design/nv_write_guard.sv
// power-up state and inadvertent-write protection of the serial nonvolatile store
`timescale 1ns/1ps
`default_nettype none
// Operation
// - after power-up stay in standby, no serial activity until host selects.
// - first instruction accepted only after a high-to-low select edge.
// - serial output floats at power-up.
// - power-up clears the write enable latch.
// - power-up clears the status flag bit.
// - supervisor reset asserted at power-up for the power-up reset time.
// - no nonvolatile write unless enable latch set by its own transaction.
// - write cycle starts only when select rises on a byte boundary.
// - block protected array regions refuse writes but stay readable.
// - write-protect pin low blocks every array and status write.
// - self-timed write ends within 10 ms of the closing select rise.
// - latch clears after each completed write and whenever write-protect drops.
// - busy bit is one exactly during the write; status stays readable.
// - select must rise right after bit 0 of the last data byte.
module nv_write_guard
  import nvg_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned WC_CNT = WC_CYCLES,
  parameter logic [7:0] SET_WRITE_ENABLE_CMD = 8'h06
)(
  // system
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // write protect pin, low blocks writes
  input wire logic wp_n,
  // supervisor and status
  output logic sup_reset,
  output logic standby,
  output logic write_busy_flag,
  output logic write_enable_latch_bit,
  output logic status_flag,
  output logic [1:0] block_protect,
  output logic [1:0] watchdog_sel
);

  localparam int POR_W = $clog2(POR_CNT + 1);
  localparam int WC_W = $clog2(WC_CNT + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CNT - 1);
  localparam logic [WC_W-1:0] WC_LAST = WC_W'(WC_CNT - 1);
  localparam logic [4:0] COPY_END = 5'h11;

  typedef enum {ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_SR, ST_SRDONE, ST_SKIP} cmd_state_t;

  // synchronisers for the pins and the link domain
  logic cs_m_r, cs_s_r, cs_d_r;
  logic wp_m_r, wp_s_r;
  logic tgl_m_r, tgl_s_r, tgl_d_r;
  logic part_m_r, part_s_r;

  // link side
  logic [7:0] rx_byte;
  logic rx_tgl, rx_partial;
  logic link_re;
  logic [ADDR_W-1:0] link_raddr;
  logic [DATA_W-1:0] arr_rdata;

  // core state
  logic [POR_W-1:0] por_cnt_r, por_cnt_nxt;
  logic sup_reset_r, sup_reset_nxt;
  cmd_state_t st_r, st_nxt;
  logic armed_r, armed_nxt;
  logic latch_r, latch_nxt;
  logic busy_r, busy_nxt;
  logic flag_r, flag_nxt;
  logic [3:0] sr_nv_r, sr_nv_nxt;
  logic [3:0] sr_new_r, sr_new_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [4:0] nbytes_r, nbytes_nxt;
  logic [15:0] valid_r, valid_nxt;
  logic [WC_W-1:0] wc_cnt_r, wc_cnt_nxt;
  logic [4:0] cp_idx_r, cp_idx_nxt;
  logic cp_sr_r, cp_sr_nxt;
  logic standby_r, standby_nxt;

  // per-cycle terms
  logic rx_evt, cs_rise, cs_fall, protected_page, go_arr, go_sr;
  logic buf_we, buf_re, arr_we;
  logic [3:0] cp_m1;
  logic [DATA_W-1:0] buf_rdata;

  function automatic logic page_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bl);
    case (bl)
      2'h0: page_protected = 1'b0;
      2'h1: page_protected = (a >= PROT_QUARTER);
      2'h2: page_protected = (a >= PROT_HALF);
      default: page_protected = 1'b1;
    endcase
  endfunction : page_protected

  spi_link u_link (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .rst(rst),
    .armed(armed_r),
    .status_word({2'b00, sr_nv_r, latch_r, busy_r}),
    .mem_re(link_re),
    .mem_raddr(link_raddr),
    .mem_rdata(arr_rdata),
    .rx_byte_r(rx_byte),
    .rx_tgl_r(rx_tgl),
    .partial_r(rx_partial)
  );

  // page buffer collects data until the select rise decides the write
  nv_mem #(.AW(PAGE_W), .DW(DATA_W)) u_page (
    .wclk(clk),
    .we(buf_we),
    .waddr(addr_r[PAGE_W-1:0]),
    .wdata(rx_byte),
    .rclk(clk),
    .re(buf_re),
    .raddr(cp_idx_r[PAGE_W-1:0]),
    .rdata(buf_rdata)
  );

  // array: written from the core, read straight from the link clock
  nv_mem #(.AW(ADDR_W), .DW(DATA_W)) u_array (
    .wclk(clk),
    .we(arr_we),
    .waddr({addr_r[ADDR_W-1:PAGE_W], cp_m1}),
    .wdata(buf_rdata),
    .rclk(sck),
    .re(link_re),
    .raddr(link_raddr),
    .rdata(arr_rdata)
  );

  always_ff @(posedge clk)
  begin
    cs_m_r <= cs_n;
    cs_s_r <= cs_m_r;
    cs_d_r <= cs_s_r;
    wp_m_r <= wp_n;
    wp_s_r <= wp_m_r;
    tgl_m_r <= rx_tgl;
    tgl_s_r <= tgl_m_r;
    tgl_d_r <= tgl_s_r;
    part_m_r <= rx_partial;
    part_s_r <= part_m_r;
  end

  // supervisor reset held for the power-up time after reset release
  always_comb
  begin
    por_cnt_nxt = por_cnt_r;
    sup_reset_nxt = sup_reset_r;
    if (sup_reset_r)
    begin
      if (por_cnt_r == POR_LAST)
      begin
        sup_reset_nxt = 1'b0;
      end
      else
      begin
        por_cnt_nxt = por_cnt_r + 1'b1;
      end
    end
  end

  always_comb
  begin
    rx_evt = tgl_s_r ^ tgl_d_r;
    cs_rise = cs_s_r & ~cs_d_r;
    cs_fall = ~cs_s_r & cs_d_r;
    protected_page = page_protected(addr_r, sr_nv_r[1:0]);
    st_nxt = st_r;
    armed_nxt = armed_r | cs_s_r;
    latch_nxt = latch_r;
    busy_nxt = busy_r;
    flag_nxt = flag_r;
    sr_nv_nxt = sr_nv_r;
    sr_new_nxt = sr_new_r;
    addr_nxt = addr_r;
    nbytes_nxt = nbytes_r;
    valid_nxt = valid_r;
    wc_cnt_nxt = wc_cnt_r;
    cp_idx_nxt = cp_idx_r;
    cp_sr_nxt = cp_sr_r;
    buf_we = 1'b0;
    go_arr = 1'b0;
    go_sr = 1'b0;
    if (rx_evt)
    begin
      case (st_r)
        ST_OP:
        begin
          st_nxt = ST_SKIP;
          // while busy the core takes no instruction; status and array reads are answered by the link
          if (!busy_r)
          begin
            if (rx_byte == SET_WRITE_ENABLE_CMD)
            begin
              latch_nxt = 1'b1;
            end
            else if (rx_byte == OP_WRDI)
            begin
              latch_nxt = 1'b0;
            end
            else if ((rx_byte & ~OP_A8_MASK) == OP_WRITE)
            begin
              st_nxt = ST_ADDR;
              addr_nxt[ADDR_W-1] = rx_byte[OP_A8_BIT];
              nbytes_nxt = 5'h00;
              valid_nxt = 16'h0000;
            end
            else if (rx_byte == OP_WRSR)
            begin
              st_nxt = ST_SR;
            end
          end
        end
        ST_ADDR:
        begin
          addr_nxt[7:0] = rx_byte;
          st_nxt = ST_DATA;
        end
        ST_DATA:
        begin
          // the address rolls over inside the page, later bytes overwrite
          buf_we = 1'b1;
          valid_nxt[addr_r[PAGE_W-1:0]] = 1'b1;
          addr_nxt[PAGE_W-1:0] = addr_r[PAGE_W-1:0] + 4'h1;
          if (nbytes_r != 5'h10)
          begin
            nbytes_nxt = nbytes_r + 5'h01;
          end
        end
        ST_SR:
        begin
          sr_new_nxt = rx_byte[SR_NV_HI:SR_NV_LO];
          st_nxt = ST_SRDONE;
        end
        ST_SRDONE:
        begin
          st_nxt = ST_SKIP;
        end
        default:
        begin
          st_nxt = st_r;
        end
      endcase
    end
    if (cs_fall && armed_r)
    begin
      st_nxt = ST_OP;
    end
    if (cs_rise)
    begin
      st_nxt = ST_IDLE;
      // a partly shifted byte at the select rise spoils the sequence
      go_arr = (st_r == ST_DATA) && nbytes_r != 5'h00 && !part_s_r
        && latch_r && wp_s_r && !protected_page && !busy_r;
      go_sr = (st_r == ST_SRDONE) && !part_s_r
        && latch_r && wp_s_r && !busy_r;
      if (go_arr || go_sr)
      begin
        busy_nxt = 1'b1;
        wc_cnt_nxt = '0;
        cp_idx_nxt = 5'h00;
        cp_sr_nxt = go_sr;
      end
      else if (st_r == ST_ADDR || st_r == ST_DATA || st_r == ST_SR || st_r == ST_SRDONE)
      begin
        flag_nxt = 1'b1;
      end
    end
    if (busy_r)
    begin
      if (cp_idx_r != COPY_END)
      begin
        cp_idx_nxt = cp_idx_r + 5'h01;
      end
      if (wc_cnt_r == WC_LAST)
      begin
        busy_nxt = 1'b0;
        latch_nxt = 1'b0;
        if (cp_sr_r)
        begin
          sr_nv_nxt = sr_new_r;
        end
      end
      else
      begin
        wc_cnt_nxt = wc_cnt_r + 1'b1;
      end
    end
    if (!wp_s_r)
    begin
      latch_nxt = 1'b0;
    end
    standby_nxt = (st_nxt == ST_IDLE);
  end

  // copy pipeline: buffer read in one cycle, array write in the next
  always_comb
  begin
    cp_m1 = 4'(cp_idx_r - 5'h01);
    buf_re = busy_r && !cp_sr_r && cp_idx_r < 5'h10;
    arr_we = busy_r && !cp_sr_r && cp_idx_r != 5'h00 && cp_idx_r != COPY_END
      && valid_r[cp_m1];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      por_cnt_r <= '0;
      sup_reset_r <= 1'b1;
      st_r <= ST_IDLE;
      armed_r <= 1'b0;
      latch_r <= 1'b0;
      busy_r <= 1'b0;
      flag_r <= 1'b0;
      sr_nv_r <= SR_NV_RESET;
      sr_new_r <= SR_NV_RESET;
      addr_r <= '0;
      nbytes_r <= 5'h00;
      valid_r <= 16'h0000;
      wc_cnt_r <= '0;
      cp_idx_r <= 5'h00;
      cp_sr_r <= 1'b0;
      standby_r <= 1'b1;
    end
    else
    begin
      por_cnt_r <= por_cnt_nxt;
      sup_reset_r <= sup_reset_nxt;
      st_r <= st_nxt;
      armed_r <= armed_nxt;
      latch_r <= latch_nxt;
      busy_r <= busy_nxt;
      flag_r <= flag_nxt;
      sr_nv_r <= sr_nv_nxt;
      sr_new_r <= sr_new_nxt;
      addr_r <= addr_nxt;
      nbytes_r <= nbytes_nxt;
      valid_r <= valid_nxt;
      wc_cnt_r <= wc_cnt_nxt;
      cp_idx_r <= cp_idx_nxt;
      cp_sr_r <= cp_sr_nxt;
      standby_r <= standby_nxt;
    end
  end

  // serial output floats whenever the link is deselected
  assign sup_reset = sup_reset_r;
  assign standby = standby_r;
  assign write_busy_flag = busy_r;
  assign write_enable_latch_bit = latch_r;
  assign status_flag = flag_r;
  assign block_protect = sr_nv_r[1:0];
  assign watchdog_sel = sr_nv_r[3:2];

endmodule : nv_write_guard
`default_nettype wire

// ### inc/nvg_pkg.sv
// constants shared by the write guard, its serial link and its memories
`default_nettype none
package nvg_pkg;

  // instruction codes, most significant bit first on the link
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_A8_MASK = 8'h08;
  localparam int OP_A8_BIT = 3;

  // array geometry
  localparam int ADDR_W = 9;
  localparam int PAGE_W = 4;
  localparam int DATA_W = 8;

  // status byte layout
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_LATCH_BIT = 1;
  localparam int SR_NV_LO = 2;
  localparam int SR_NV_HI = 5;
  localparam logic [3:0] SR_NV_RESET = 4'hc;

  // lowest protected address for block protect settings 1 and 2
  localparam logic [8:0] PROT_QUARTER = 9'h180;
  localparam logic [8:0] PROT_HALF = 9'h100;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int POWER_UP_RESET_TIME_MS = 100;
  localparam int NV_WRITE_CYCLE_TIME_MS = 10;
  localparam int POR_CYCLES = POWER_UP_RESET_TIME_MS * (CLK_HZ / 1000);
  localparam int WC_CYCLES = NV_WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);

endpackage : nvg_pkg
`default_nettype wire

// ### design/nv_mem.sv
// simple two-clock memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module nv_mem #(
  parameter int AW = 9,
  parameter int DW = 8
)(
  // write side
  input wire logic wclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read side
  input wire logic rclk,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge wclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge rclk)
  begin
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : nv_mem
`default_nettype wire

// ### design/spi_link.sv
// serial link front end running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_link
  import nvg_pkg::*;
(
  // link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // from the core clock domain
  input wire logic rst,
  input wire logic armed,
  input wire logic [7:0] status_word,
  // array read port
  output logic mem_re,
  output logic [ADDR_W-1:0] mem_raddr,
  input wire logic [DATA_W-1:0] mem_rdata,
  // to the core clock domain
  output logic [7:0] rx_byte_r,
  output logic rx_tgl_r,
  output logic partial_r
);

  typedef enum {M_NONE, M_RDSR, M_READ} rd_mode_t;

  logic first_r;
  logic arm_m_r, arm_s_r;
  logic [7:0] sts_m_r, sts_s_r;
  logic [2:0] bit_cnt_r, bit_cnt_nxt, cnt_base;
  logic [1:0] idx_r, idx_nxt, idx_base;
  logic [7:0] sh_r, sh_nxt, rx_byte_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic rx_tgl_nxt, partial_nxt;
  rd_mode_t mode_r, mode_nxt, mode_base;
  logic [7:0] tx_r, tx_nxt;
  logic so_nxt, so_oe_nxt;

  // first edge of a frame restarts counting; the counters themselves keep their
  // value after the frame so the core can still see where the select rose
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      first_r <= 1'b1;
      arm_m_r <= 1'b0;
      arm_s_r <= 1'b0;
    end
    else
    begin
      first_r <= 1'b0;
      arm_m_r <= armed;
      arm_s_r <= arm_m_r;
    end
  end

  // status bits are independent levels, each synchronised on its own
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      sts_m_r <= 8'h00;
      sts_s_r <= 8'h00;
    end
    else
    begin
      sts_m_r <= status_word;
      sts_s_r <= sts_m_r;
    end
  end

  always_comb
  begin
    cnt_base = first_r ? 3'h0 : bit_cnt_r;
    idx_base = first_r ? 2'h0 : idx_r;
    mode_base = first_r ? M_NONE : mode_r;
    sh_nxt = {sh_r[6:0], si};
    bit_cnt_nxt = cnt_base + 3'h1;
    partial_nxt = (bit_cnt_nxt != 3'h0);
    idx_nxt = idx_base;
    mode_nxt = mode_base;
    addr_nxt = first_r ? '0 : addr_r;
    rx_byte_nxt = rx_byte_r;
    rx_tgl_nxt = rx_tgl_r;
    mem_re = 1'b0;
    mem_raddr = addr_nxt;
    if (cnt_base == 3'h7)
    begin
      rx_byte_nxt = sh_nxt;
      rx_tgl_nxt = ~rx_tgl_r;
      if (idx_base != 2'h3)
      begin
        idx_nxt = idx_base + 2'h1;
      end
      // reads are answered here: the core is too far away to turn a byte round
      if (idx_base == 2'h0 && arm_s_r)
      begin
        if (sh_nxt == OP_RDSR)
        begin
          mode_nxt = M_RDSR;
        end
        else if ((sh_nxt & ~OP_A8_MASK) == OP_READ)
        begin
          mode_nxt = M_READ;
          addr_nxt[ADDR_W-1] = sh_nxt[OP_A8_BIT];
        end
      end
      else if (mode_base == M_READ && idx_base != 2'h0)
      begin
        mem_re = 1'b1;
        mem_raddr = (idx_base == 2'h1) ? {addr_r[ADDR_W-1], sh_nxt} : addr_r;
        addr_nxt = mem_raddr + 9'h001;
      end
    end
  end

  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_r <= 3'h0;
      idx_r <= 2'h0;
      sh_r <= 8'h00;
      addr_r <= '0;
      mode_r <= M_NONE;
      rx_byte_r <= 8'h00;
      rx_tgl_r <= 1'b0;
      partial_r <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      addr_r <= addr_nxt;
      mode_r <= mode_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_tgl_r <= rx_tgl_nxt;
      partial_r <= partial_nxt;
    end
  end

  // output is shifted on the falling edge; deselect floats it at once
  always_comb
  begin
    tx_nxt = {tx_r[6:0], 1'b0};
    so_nxt = tx_r[7];
    so_oe_nxt = so_oe;
    if (bit_cnt_r == 3'h0 && mode_r != M_NONE)
    begin
      tx_nxt = (mode_r == M_RDSR) ? sts_s_r : mem_rdata;
      so_nxt = tx_nxt[7];
      tx_nxt = {tx_nxt[6:0], 1'b0};
      so_oe_nxt = 1'b1;
    end
  end

  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      tx_r <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      tx_r <= tx_nxt;
      so <= so_nxt;
      so_oe <= so_oe_nxt;
    end
  end

endmodule : spi_link
`default_nettype wire

// ### testbench/nv_write_guard_monitor.sv
// port-level checks of the write guard
`timescale 1ns/1ps
`default_nettype none
module nv_write_guard_monitor
  import nvg_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned WC_CNT = WC_CYCLES
)(
  // system
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic wp_n,
  // supervisor and status
  input wire logic sup_reset,
  input wire logic standby,
  input wire logic write_busy_flag,
  input wire logic write_enable_latch_bit,
  input wire logic status_flag,
  input wire logic [1:0] block_protect,
  input wire logic [1:0] watchdog_sel
);
  logic [31:0] por_cnt_r, por_cnt_nxt, busy_cnt_r, busy_cnt_nxt;

  // the power-up count saturates, so a long run never wraps back into the hold window
  always_comb
  begin
    por_cnt_nxt = (por_cnt_r > POR_CNT + 2) ? por_cnt_r : por_cnt_r + 32'h1;
    busy_cnt_nxt = write_busy_flag ? busy_cnt_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge clk)
  begin
    por_cnt_r <= rst ? 32'h0 : por_cnt_nxt;
    busy_cnt_r <= rst ? 32'h0 : busy_cnt_nxt;
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reset_state: assert property ($fell(rst) |-> sup_reset && standby
      && !write_enable_latch_bit && !write_busy_flag && !status_flag)
    else $error("outputs not in power-up state after reset");
  a_por_hold: assert property (por_cnt_r + 32'h1 < POR_CNT |-> sup_reset)
    else $error("supervisor reset released early");
  a_por_release: assert property (por_cnt_r > POR_CNT |-> !sup_reset)
    else $error("supervisor reset held too long");
  a_so_float: assert property (cs_n |-> !so_oe)
    else $error("serial output driven while deselected");
  a_standby_idle: assert property (cs_n [*6] |-> standby)
    else $error("not in standby while deselected");
  a_busy_length: assert property ($fell(write_busy_flag) |-> busy_cnt_r == WC_CNT)
    else $error("write cycle length wrong");
  a_latch_autoclear: assert property ($fell(write_busy_flag) |-> !write_enable_latch_bit)
    else $error("enable latch left set after write");
  a_wp_clears: assert property (!wp_n [*4] |=> !write_enable_latch_bit)
    else $error("enable latch not cleared by protect pin");
  a_needs_latch: assert property ($rose(write_busy_flag) |-> $past(write_enable_latch_bit))
    else $error("write started without enable latch");
  a_needs_wp: assert property ($rose(write_busy_flag) |-> $past(wp_n, 4))
    else $error("write started while protect pin low");
  a_flag_sticky: assert property (!$fell(status_flag))
    else $error("status flag cleared outside reset");
endmodule : nv_write_guard_monitor

bind nv_write_guard nv_write_guard_monitor #(.POR_CNT(POR_CNT), .WC_CNT(WC_CNT)) u_mon (
  .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
  .sup_reset(sup_reset), .standby(standby), .write_busy_flag(write_busy_flag),
  .write_enable_latch_bit(write_enable_latch_bit), .status_flag(status_flag),
  .block_protect(block_protect), .watchdog_sel(watchdog_sel));
`default_nettype wire

// ### testbench/spi_host.sv
// host controller model driving the serial link on its own clock
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  // link pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // sends n bits from d[31] down; serial clock runs only inside the frame
  task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] q);
    q = '0;
    cs_n = 1'b0;  // frame opens on a high-to-low select edge
    #250;
    for (int i = 31; i > 31 - n; i--)
    begin
      si = d[i];
      #24 sck = 1'b1;
      q = {q[30:0], so_oe ? so : 1'bx};
      #24 sck = 1'b0;
    end
    #200;
    cs_n = 1'b1;  // rises right after the last bit handed
    si = ~si;  // released line must not keep its last value
    #300;
  endtask : xfer
endmodule : spi_host
`default_nettype wire

// ### testbench/tb_nv_write_guard.sv
// self-checking bench for the write guard
`timescale 1ns/1ps
`default_nettype none
module tb_nv_write_guard
  import nvg_pkg::*;
;
  localparam int POR = 50;
  localparam int WC = 40;
  localparam logic [7:0] SET_EN_OP = 8'h06;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  wire logic sck, cs_n, si, so, so_oe, sup, stby, busy, latch, sflag;
  wire logic [1:0] bp, wds;
  logic [31:0] q;
  logic [8:0] ad [2] = '{9'h000, 9'h1ff};
  logic [7:0] dd [2];
  logic [7:0] d;
  logic [8:0] a;
  int error_cnt = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  nv_write_guard #(.POR_CNT(POR), .WC_CNT(WC), .SET_WRITE_ENABLE_CMD(SET_EN_OP)) u_nv_write_guard (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .sup_reset(sup), .standby(stby), .write_busy_flag(busy), .write_enable_latch_bit(latch),
    .status_flag(sflag), .block_protect(bp), .watchdog_sel(wds));
  spi_host u_spi_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  function automatic logic exp_ok(input logic [1:0] bl, input logic [8:0] ea, input int n);
    return wp_n && n == 24 && !(bl == 2'd3 || (bl == 2'd2 && ea >= 9'h100)
        || (bl == 2'd1 && ea >= 9'h180));
  endfunction : exp_ok

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [8:0] wa, input logic [7:0] v, input int n);
    u_spi_host.xfer({OP_WRITE | (wa[8] ? OP_A8_MASK : 8'h00), wa[7:0], v, v}, n, q);
  endtask : wr

  task automatic rd(input logic [8:0] ra, input logic [7:0] v);
    u_spi_host.xfer({OP_READ | (ra[8] ? OP_A8_MASK : 8'h00), ra[7:0], 16'h0000}, 24, q);
    chk(q[7:0], v);
  endtask : rd

  // polls the busy bit over the link, as a host must before its next write
  task automatic wait_done;
    u_spi_host.xfer({OP_RDSR, 24'h000000}, 16, q);
    chk(q[0], 1'b1);
    for (int i = 0; i < 20 && q[0] !== 1'b0; i++)
      u_spi_host.xfer({OP_RDSR, 24'h000000}, 16, q);
    chk(q[1:0], 2'b00);
  endtask : wait_done

  task automatic attempt(input logic [8:0] wa, input logic [7:0] v, input int n, input logic ok);
    u_spi_host.xfer({SET_EN_OP, 24'h000000}, 8, q);
    @(negedge clk);
    chk(latch, wp_n);
    wr(wa, v, n);
    repeat (8) @(posedge clk);
    #1;
    chk(busy, ok);
    if (ok)
      wait_done();
    else
      chk({sflag, latch}, {1'b1, wp_n});
  endtask : attempt

  initial
  begin
    void'($urandom(43));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({sup, stby, so_oe, latch, busy, sflag}, 6'h30);
    repeat (POR) @(posedge clk);
    #1;
    chk(sup, 1'b0);
    $display("test power_up done");
    wr(9'h010, 8'h5a, 24);
    repeat (8) @(posedge clk);
    #1;
    chk({busy, sflag}, 2'b01);
    $display("test no_enable done");
    for (int k = 0; k < 6; k++)
    begin
      d = 8'($urandom);
      a = (k < 2) ? ad[k] : 9'h001 + 9'($urandom % 510);
      if (k < 2)
        dd[k] = d;
      attempt(a, d, 24, 1'b1);
      rd(a, d);
    end
    $display("test write_read done");
    attempt(9'h020, 8'h77, 27, 1'b0);
    @(posedge clk) wp_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk(latch, 1'b0);
    attempt(9'h030, 8'h33, 24, exp_ok(2'd0, 9'h030, 24));
    @(posedge clk) wp_n <= 1'b1;
    $display("test protect_pin done");
    for (int b = 1; b < 4; b++)
    begin
      u_spi_host.xfer({SET_EN_OP, 24'h000000}, 8, q);
      u_spi_host.xfer({OP_WRSR, 4'h3, 2'(b), 2'b00, 16'h0000}, 16, q);
      repeat (8) @(posedge clk);
      wait_done();
      @(negedge clk);
      chk({wds, bp}, {2'b11, 2'(b)});
      for (int k = 0; k < 2; k++)
      begin
        d = 8'($urandom);
        attempt(ad[k], d, 24, exp_ok(2'(b), ad[k], 24));
        if (exp_ok(2'(b), ad[k], 24))
          dd[k] = d;
        rd(ad[k], dd[k]);
      end
      $display("test block_protect %0d done", b);
    end
    print_verdict();
  end

  initial
  begin
    #3_000_000;
    error_cnt++;
    print_verdict();
  end
endmodule : tb_nv_write_guard
`default_nettype wire
